// ---- verilog/gpc_pkg.sv ----
// package for the general purpose pin controller
// assumes a single 200 MHz core clock and plain control ports, no register bus
package gpc_pkg;

  // number of general purpose pins
  localparam int unsigned PIN_COUNT = 7;

  // core clock and interrupt sampling clock rates
  localparam int unsigned CORE_CLK_MHZ   = 200;
  localparam int unsigned SAMPLE_CLK_MHZ = 25;

  // core cycles per sampling tick (200 / 25 = 8)
  localparam int unsigned SAMPLE_DIV     = CORE_CLK_MHZ / SAMPLE_CLK_MHZ;
  localparam int unsigned SAMPLE_CNT_W   = $clog2(SAMPLE_DIV);

  // consecutive qualifying samples needed to recognise a level
  localparam int unsigned QUAL_SAMPLES   = 2;

  // direction encoding: one is output, zero is input
  localparam logic DIR_OUTPUT = 1'b1;
  localparam logic DIR_INPUT  = 1'b0;

  // buffer type encoding: one is open-drain, zero is push-pull
  localparam logic BUF_OPEN_DRAIN = 1'b1;
  localparam logic BUF_PUSH_PULL  = 1'b0;

  // output source select: two bits per pin, a from sel_a, b from sel_b
  typedef enum logic [1:0] {
    SRC_DATA = 2'b00,
    SRC_ALT0 = 2'b01,
    SRC_ALT1 = 2'b11,
    SRC_ALT2 = 2'b10
  } gpc_src_e;

  // reset values of the configuration state
  localparam logic [PIN_COUNT-1:0] RST_ZERO = 7'h00;

endpackage : gpc_pkg

// ---- verilog/gpc_pin_controller.sv ----
// seven general purpose pins shared with normal device functions, with
// per-pin direction, buffer type, source select and level interrupts
// assumes synchronous pin inputs and a configuration master on plain ports
//
// Behaviour
// - seven bidirectional pins, each configured by its own control bits
// - pin acts as general purpose only while its enable bit is set
// - input direction turns pull-up on; data reads live input level
// - output pins choose push-pull or open-drain per pin
// - open-drain drives low for data zero, undriven for data one
// - push-pull drives the data bit value onto the pin
// - output pins keep pull-up off, input buffer on; data reads pin
// - pull-up on only as general purpose input, unless normal function needs it
// - each pin has its own interrupt status bit, held set until cleared
// - enabled statuses combine into one pin interrupt signal
// - status sets on its event regardless of interrupt enable
// - level recognised after two consecutive 25 MHz samples
// - polarity one: high level triggers; zero: low level triggers
// - enabled pin output source chosen by two source select fields
// - buffer type applies to every output source
module gpc_pin_controller #(
  parameter int unsigned PINS = gpc_pkg::PIN_COUNT
) (
  input  wire logic            core_clk,
  input  wire logic            resetn,
  // configuration bits, one per pin, and a single data write strobe
  input  wire logic [PINS-1:0] pin_enable,
  input  wire logic [PINS-1:0] pin_direction,
  input  wire logic [PINS-1:0] pin_data_wr,
  input  wire logic            pin_data_wr_stb,
  input  wire logic [PINS-1:0] pin_buffer_type,
  input  wire logic [PINS-1:0] pin_irq_polarity,
  input  wire logic [PINS-1:0] pin_irq_enable,
  input  wire logic [PINS-1:0] pin_output_source_sel_a,
  input  wire logic [PINS-1:0] pin_output_source_sel_b,
  input  wire logic [PINS-1:0] pin_irq_status_clr,
  // normal and alternate functions feeding the shared pins
  input  wire logic [PINS-1:0] func_out,
  input  wire logic [PINS-1:0] func_oe,
  input  wire logic [PINS-1:0] func_pullup,
  input  wire logic [PINS-1:0] alt0_out,
  input  wire logic [PINS-1:0] alt1_out,
  input  wire logic [PINS-1:0] alt2_out,
  // pad side
  input  wire logic [PINS-1:0] pad_in,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe,
  output logic      [PINS-1:0] pad_pullup,
  // status
  output logic      [PINS-1:0] pin_data_rd,
  output logic      [PINS-1:0] pin_irq_status,
  output logic                 pin_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // stored data bits

  logic [PINS-1:0] data_reg;

  // written value only steers the drivers; reads always see the pad
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      data_reg <= gpc_pkg::RST_ZERO[PINS-1:0];
    else if (pin_data_wr_stb)
      data_reg <= pin_data_wr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive selection

  logic [PINS-1:0] src_val;
  logic [PINS-1:0] oe_next;
  logic [PINS-1:0] out_next;
  logic [PINS-1:0] pu_next;

  // per-pin source mux, buffer type and pull-up choice
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      unique case (gpc_pkg::gpc_src_e'({pin_output_source_sel_b[i], pin_output_source_sel_a[i]}))
        gpc_pkg::SRC_DATA: src_val[i] = data_reg[i];
        gpc_pkg::SRC_ALT0: src_val[i] = alt0_out[i];
        gpc_pkg::SRC_ALT1: src_val[i] = alt1_out[i];
        gpc_pkg::SRC_ALT2: src_val[i] = alt2_out[i];
      endcase
      if (!pin_enable[i])
      begin
        // normal function keeps the pin
        out_next[i] = func_out[i];
        oe_next[i]  = func_oe[i];
        pu_next[i]  = func_pullup[i];
      end
      else if (pin_direction[i] == gpc_pkg::DIR_OUTPUT)
      begin
        pu_next[i] = 1'b0;
        if (pin_buffer_type[i] == gpc_pkg::BUF_OPEN_DRAIN)
        begin
          // open-drain: drive low only, release for one
          out_next[i] = 1'b0;
          oe_next[i]  = ~src_val[i];
        end
        else
        begin
          out_next[i] = src_val[i];
          oe_next[i]  = 1'b1;
        end
      end
      else
      begin
        out_next[i] = 1'b0;
        oe_next[i]  = 1'b0;
        pu_next[i]  = 1'b1;
      end
    end
  end

  // registered pad controls; reset leaves every pin released as input
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pad_out    <= gpc_pkg::RST_ZERO[PINS-1:0];
      pad_oe     <= gpc_pkg::RST_ZERO[PINS-1:0];
      pad_pullup <= gpc_pkg::RST_ZERO[PINS-1:0];
    end
    else
    begin
      pad_out    <= out_next;
      pad_oe     <= oe_next;
      pad_pullup <= pu_next;
    end
  end

  // data reads return the pad level whatever the direction
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pin_data_rd <= gpc_pkg::RST_ZERO[PINS-1:0];
    else
      pin_data_rd <= pad_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz sampling tick derived from the core clock

  logic [gpc_pkg::SAMPLE_CNT_W-1:0] tick_cnt_reg;
  logic                             tick;

  assign tick = (tick_cnt_reg == gpc_pkg::SAMPLE_CNT_W'(gpc_pkg::SAMPLE_DIV - 1));

  // free running divider; a tick every eighth core cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // level qualification and sticky status

  logic [PINS-1:0] active;
  logic [PINS-1:0] prev_active_reg;
  logic [PINS-1:0] qualified;

  // polarity picks which level counts as active
  assign active    = ~(pad_in ^ pin_irq_polarity);
  // two consecutive sampling edges both active; shorter glitches are lost
  assign qualified = {PINS{tick}} & active & prev_active_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      prev_active_reg <= gpc_pkg::RST_ZERO[PINS-1:0];
    else if (tick)
      prev_active_reg <= active;
  end

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pin_irq_status <= gpc_pkg::RST_ZERO[PINS-1:0];
    else
      pin_irq_status <= (pin_irq_status & ~pin_irq_status_clr) | qualified;
  end

  // enabled statuses merged onto the single interrupt line, one cycle behind
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pin_irq <= 1'b0;
    else
      pin_irq <= |(pin_irq_status & pin_irq_enable);
  end

endmodule // gpc_pin_controller

// ---- verification/gpc_pin_controller_assertions.sv ----
// checker: pad drive, pull-up, read-back, status and interrupt relations
// assumes binding to gpc_pin_controller, seeing only its ports
module gpc_pin_controller_chk #(
  parameter int unsigned PINS = 7
) (
  input wire logic            core_clk,
  input wire logic            resetn,
  input wire logic [PINS-1:0] pin_enable,
  input wire logic [PINS-1:0] pin_direction,
  input wire logic [PINS-1:0] pin_buffer_type,
  input wire logic [PINS-1:0] pin_irq_polarity,
  input wire logic [PINS-1:0] pin_irq_enable,
  input wire logic [PINS-1:0] pin_irq_status_clr,
  input wire logic [PINS-1:0] func_oe,
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pad_pullup,
  input wire logic [PINS-1:0] pin_data_rd,
  input wire logic [PINS-1:0] pin_irq_status,
  input wire logic            pin_irq
);
  logic [1:0]      up_reg;
  wire [PINS-1:0] gp_in = pin_enable & ~pin_direction;
  wire [PINS-1:0] od    = pin_enable & pin_direction & pin_buffer_type;
  // two edges of grace after reset: outputs still carry reset values at the first
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) up_reg <= 2'h0;
    else up_reg <= {up_reg[0], 1'b1};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!up_reg[1]);
  // every pad control is registered once from its configuration
  a_func_pass: assert property ((pad_oe & ~$past(pin_enable)) == $past(func_oe & ~pin_enable)) else $error("pass");
  a_pullup_gp: assert property ((pad_pullup & $past(pin_enable)) == $past(gp_in)) else $error("pullup");
  a_input_oe: assert property ((pad_oe & $past(gp_in)) == '0) else $error("input oe");
  a_od_low: assert property ((pad_out & $past(od)) == '0) else $error("od out");
  a_read_live: assert property (pin_data_rd == $past(pad_in)) else $error("read");
  a_irq_or: assert property (pin_irq == |$past(pin_irq_status & pin_irq_enable)) else $error("irq");
  a_status_kept: assert property (($past(pin_irq_status & ~pin_irq_status_clr) & ~pin_irq_status) == '0)
    else $error("sticky");
  a_status_pol: assert property ((pin_irq_status & ~$past(pin_irq_status) & $past(pad_in ^ pin_irq_polarity)) == '0)
    else $error("polarity");
endmodule // gpc_pin_controller_chk
bind gpc_pin_controller gpc_pin_controller_chk #(.PINS(PINS)) i_chk (.core_clk, .resetn, .pin_enable, .pin_direction,
  .pin_buffer_type, .pin_irq_polarity, .pin_irq_enable, .pin_irq_status_clr, .func_oe, .pad_in, .pad_out, .pad_oe,
  .pad_pullup, .pin_data_rd, .pin_irq_status, .pin_irq);

// ---- verification/gpc_board_model.sv ----
// board side of the shared pads: device drive, board drive, pull-up or float
// assumes the bench steers ext_oe and ext_val
module gpc_board_model (
  input  wire logic       core_clk,
  input  wire logic [6:0] pad_out,
  input  wire logic [6:0] pad_oe,
  input  wire logic [6:0] pad_pullup,
  input  wire logic [6:0] ext_oe,
  input  wire logic [6:0] ext_val,
  output logic      [6:0] pad_in
);
  logic [6:0] flt = 7'h00;
  // an undriven pad without pull-up must not hold a level
  always @(posedge core_clk) flt <= ~flt;
  // board drives only released pads; no strap loading happens in this model
  assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_oe & ext_val | ~ext_oe & (pad_pullup | flt));
endmodule // gpc_board_model

// ---- verification/gpc_pin_controller_test.sv ----
// self-checking bench for the pin controller: pads, read-back, level interrupts
// assumes the board model on the pads and a 200 MHz core clock
module gpc_pin_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 0, resetn = 0, pin_data_wr_stb = 0;
  logic [6:0] pin_enable = 0, pin_direction = 0, pin_data_wr = 0, pin_buffer_type = 0, pin_irq_polarity = 0;
  logic [6:0] pin_irq_enable = 0, pin_output_source_sel_a = 0, pin_output_source_sel_b = 0, pin_irq_status_clr = 0;
  logic [6:0] func_out = 7'h35, func_oe = 7'h5C, func_pullup = 7'h23, ext_oe = 0, ext_val = 0;
  logic [6:0] alt [3] = '{7'h11, 7'h5A, 7'h66};
  wire  [6:0] pad_in, pad_out, pad_oe, pad_pullup, pin_data_rd, pin_irq_status;
  wire        pin_irq;
  int         miscompares = 0, compares = 0, cycles = 0;
  gpc_pin_controller i_dut (.core_clk, .resetn, .pin_enable, .pin_direction, .pin_data_wr, .pin_data_wr_stb,
    .pin_buffer_type, .pin_irq_polarity, .pin_irq_enable, .pin_output_source_sel_a, .pin_output_source_sel_b,
    .pin_irq_status_clr, .func_out, .func_oe, .func_pullup, .alt0_out(alt[0]), .alt1_out(alt[1]),
    .alt2_out(alt[2]), .pad_in, .pad_out, .pad_oe, .pad_pullup, .pin_data_rd, .pin_irq_status, .pin_irq);
  gpc_board_model i_board (.core_clk, .pad_out, .pad_oe, .pad_pullup, .ext_oe, .ext_val, .pad_in);
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [6:0] seen, input logic [6:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic clr_sts();
    pin_irq_status_clr = 7'h7F;
    cyc(1);
    pin_irq_status_clr = 7'h00;
  endtask
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // out of reset every pin is disabled, so the normal function owns the pads
  task automatic t_func();
    cyc(3);
    chk("rst oe", pad_oe, 7'h00);
    resetn = 1;
    clr_sts();
    cyc(1);
    chk("out", pad_out, 7'h35);
    chk("oe", pad_oe, 7'h5C);
    chk("pull", pad_pullup, 7'h23);
  endtask
  // general purpose inputs: pull-up on, released, live read-back
  task automatic t_input();
    pin_enable = 7'h7F; ext_oe = 7'h7F; ext_val = 7'h2B;
    cyc(2);
    chk("pull", pad_pullup, 7'h7F);
    chk("oe", pad_oe, 7'h00);
    chk("rd", pin_data_rd, 7'h2B);
  endtask
  // push-pull then open-drain, with data and each alternate source
  task automatic t_output();
    ext_oe = 7'h00; pin_direction = 7'h7F; pin_data_wr = 7'h4D; pin_data_wr_stb = 1;
    cyc(1);
    pin_data_wr_stb = 0;
    cyc(2);
    chk("out", pad_out, 7'h4D);
    chk("pull", pad_pullup, 7'h00);
    chk("rd", pin_data_rd, 7'h4D);
    pin_buffer_type = 7'h7F;
    cyc(2);
    chk("od", pad_oe, 7'h32);
    for (int k = 0; k < 3; k++)
    begin
      pin_output_source_sel_a = {7{k < 2}}; pin_output_source_sel_b = {7{k > 0}}; pin_buffer_type = 7'h00;
      cyc(2);
      chk("alt", pad_out, alt[k]);
      pin_buffer_type = 7'h7F;
      cyc(2);
      chk("alt od", pad_oe, ~alt[k]);
    end
  endtask
  // polarity mix, enable gating, clear, short glitch and re-set of a held level
  task automatic t_irq();
    pin_direction = 7'h00; pin_irq_polarity = 7'h0F; ext_oe = 7'h7F; ext_val = 7'h55;
    cyc(4);
    clr_sts();
    cyc(20);
    chk("sts", pin_irq_status, 7'h25);
    chk("irq", {6'h00, pin_irq}, 7'h00);
    pin_irq_enable = 7'h20;
    cyc(2);
    chk("irq", {6'h00, pin_irq}, 7'h01);
    ext_val = 7'h70;
    clr_sts();
    cyc(1);
    chk("clr", pin_irq_status, 7'h00);
    // let one inactive tick pass, then the short pulse straddles exactly one tick
    cyc(12);
    ext_val = 7'h71;
    cyc(3);
    ext_val = 7'h70;
    cyc(20);
    chk("glitch", pin_irq_status, 7'h00);
    ext_val = 7'h55;
    cyc(20);
    clr_sts();
    cyc(20);
    chk("reset", pin_irq_status, 7'h25);
  endtask
  initial
    forever #2.5 core_clk = ~core_clk;
  // cut a hung run short
  always @(posedge core_clk)
    if (++cycles == 1000)
    begin
      miscompares++;
      close_out();
    end
  initial
  begin
    t_func();
    t_input();
    t_output();
    t_irq();
    close_out();
  end
endmodule // gpc_pin_controller_test
